// ---- logic/pmr_regs.sv ----
// interface mode, indicator override and phy control registers
`timescale 1ns/100ps
module pmr_regs
   import pmr_pkg::*;
#(
   parameter int STRETCH_CYCLES = PMR_STRETCH_CYCLES
) (
   input  wire logic        core_clk,
   input  wire logic        srst,
   // register port
   input  wire logic [4:0]  reg_addr,
   input  wire logic        reg_wr_en,
   input  wire logic        reg_rd_en,
   input  wire logic [15:0] reg_wdata,
   output logic [15:0]      reg_rdata,
   output logic             reg_rd_valid,
   // strap pins
   input  wire logic        strap_rmii,
   input  wire logic        strap_auto_crossover_enable,
   input  wire logic        strap_led_mode,
   input  wire logic [4:0]  strap_port_address,
   // datapath status
   input  wire logic        rx_fifo_overflow_evt,
   input  wire logic        rx_fifo_underflow_evt,
   input  wire logic        carrier_sense,
   input  wire logic        rx_data_valid,
   input  wire logic [1:0]  local_ability_advert,
   input  wire logic [1:0]  partner_ability_advert,
   input  wire logic        full_duplex_resolved,
   input  wire logic        auto_cross_decision,
   input  wire logic        selftest_error,
   input  wire logic        link_up,
   input  wire logic        speed_100,
   input  wire logic        activity,
   // controls out
   output logic             rmii_mode_select,
   output logic             legacy_revision_select,
   output logic [1:0]       elastic_buffer_setting,
   output logic             crs_dv,
   output logic             auto_crossover_enable,
   output logic             media_pair_swap,
   output logic             pause_rx_enable,
   output logic             pause_tx_enable,
   output logic             selftest_run,
   output logic             selftest_sequence_select,
   output logic             selftest_error_inject,
   output logic [4:0]       management_port_address,
   output logic             speed_indicator_output,
   output logic             link_indicator_output
);

   logic       rmii_s1_q, mdix_s1_q, led_s1_q;
   logic       rmii_s2_q, mdix_s2_q, led_s2_q;
   logic [4:0] addr_s1_q, addr_s2_q;
   logic       strap_pend_q;
   logic       ovf_q, unf_q;
   logic       spd_ovr_q, lnk_ovr_q, spd_val_q, lnk_val_q;
   logic       force_q, prx_q, ptx_q, fe_q, pass_q, run_prev_q;
   logic       bypass_q, led_mode_q;
   logic       wr_ifm, wr_led, wr_phy, rd_ifm;
   logic       pause_rx_d, pause_tx_d;
   logic       lp, la, pp, pa;
   logic [15:0] rdata_d;
   pmr_crs_state_t crs_st_q;

   assign wr_ifm = reg_wr_en && reg_addr == PMR_ADDR_IFMODE;
   assign wr_led = reg_wr_en && reg_addr == PMR_ADDR_LEDOVR;
   assign wr_phy = reg_wr_en && reg_addr == PMR_ADDR_PHYCTL;
   assign rd_ifm = reg_rd_en && reg_addr == PMR_ADDR_IFMODE;

   // =====================================================
   // strap synchronisers, no reset, read only by stage two
   always_ff @(posedge core_clk) begin
      rmii_s1_q <= strap_rmii;
      mdix_s1_q <= strap_auto_crossover_enable;
      led_s1_q  <= strap_led_mode;
      addr_s1_q <= strap_port_address;
      rmii_s2_q <= rmii_s1_q;
      mdix_s2_q <= mdix_s1_q;
      led_s2_q  <= led_s1_q;
      addr_s2_q <= addr_s1_q;
   end

   // straps are taken on the first edge after reset release
   always_ff @(posedge core_clk) begin
      if (srst) begin
         strap_pend_q <= 1'b1;
      end else begin
         strap_pend_q <= 1'b0;
      end
   end

   // =====================================================
   // interface mode register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         rmii_mode_select       <= 1'b0;
         legacy_revision_select <= 1'b0;
         elastic_buffer_setting <= PMR_ELAST_RESET;
      end else begin
         if (strap_pend_q) begin
            rmii_mode_select <= rmii_s2_q;
         end else if (wr_ifm) begin
            rmii_mode_select <= reg_wdata[PMR_IFM_RMII_BIT];
         end
         if (wr_ifm) begin
            legacy_revision_select <= reg_wdata[PMR_IFM_LEGACY_BIT];
            elastic_buffer_setting <= reg_wdata[PMR_IFM_ELAST_LSB +: 2];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         ovf_q <= 1'b0;
      end else if (rx_fifo_overflow_evt) begin
         ovf_q <= 1'b1;
      end else if (rd_ifm) begin
         ovf_q <= 1'b0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         unf_q <= 1'b0;
      end else if (rx_fifo_underflow_evt) begin
         unf_q <= 1'b1;
      end else if (rd_ifm) begin
         unf_q <= 1'b0;
      end
   end

   // =====================================================
   // carrier / data valid merge
   // toggle tail or hold
   always_ff @(posedge core_clk) begin
      if (srst) begin
         crs_st_q <= PMR_CRS_IDLE;
         crs_dv   <= 1'b0;
      end else if (!rmii_mode_select || legacy_revision_select) begin
         crs_st_q <= PMR_CRS_IDLE;
         crs_dv   <= carrier_sense ||
                     (legacy_revision_select && rx_data_valid);
      end else begin
         case (crs_st_q)
            PMR_CRS_IDLE: begin
               crs_dv <= carrier_sense;
               if (carrier_sense) begin
                  crs_st_q <= PMR_CRS_CARRIER;
               end
            end
            PMR_CRS_CARRIER: begin
               if (carrier_sense) begin
                  crs_dv <= 1'b1;
               end else if (rx_data_valid) begin
                  crs_dv   <= 1'b0;
                  crs_st_q <= PMR_CRS_TAIL;
               end else begin
                  crs_dv   <= 1'b0;
                  crs_st_q <= PMR_CRS_IDLE;
               end
            end
            PMR_CRS_TAIL: begin
               if (carrier_sense) begin
                  crs_dv   <= 1'b1;
                  crs_st_q <= PMR_CRS_CARRIER;
               end else if (rx_data_valid) begin
                  crs_dv <= !crs_dv;
               end else begin
                  crs_dv   <= 1'b0;
                  crs_st_q <= PMR_CRS_IDLE;
               end
            end
            default: begin
               crs_dv   <= 1'b0;
               crs_st_q <= PMR_CRS_IDLE;
            end
         endcase
      end
   end

   // =====================================================
   // indicator override register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         spd_ovr_q <= 1'b0;
         lnk_ovr_q <= 1'b0;
         spd_val_q <= 1'b0;
         lnk_val_q <= 1'b0;
      end else if (wr_led) begin
         spd_ovr_q <= reg_wdata[PMR_LED_SPD_OVR_BIT];
         lnk_ovr_q <= reg_wdata[PMR_LED_LNK_OVR_BIT];
         spd_val_q <= reg_wdata[PMR_LED_SPD_VAL_BIT];
         lnk_val_q <= reg_wdata[PMR_LED_LNK_VAL_BIT];
      end
   end

   // =====================================================
   // phy control register
   always_ff @(posedge core_clk) begin
      if (srst) begin
         auto_crossover_enable    <= 1'b0;
         led_mode_q               <= 1'b0;
         management_port_address  <= 5'h00;
         force_q                  <= 1'b0;
         selftest_sequence_select <= 1'b0;
         selftest_run             <= 1'b0;
         bypass_q                 <= 1'b0;
      end else if (strap_pend_q) begin
         auto_crossover_enable   <= mdix_s2_q;
         led_mode_q              <= led_s2_q;
         management_port_address <= addr_s2_q;
      end else if (wr_phy) begin
         auto_crossover_enable    <= reg_wdata[PMR_PHY_AUTO_CROSSOVER_ENABLE_BIT];
         force_q                  <= reg_wdata[PMR_PHY_FORCE_BIT];
         selftest_sequence_select <= reg_wdata[PMR_PHY_PSR_BIT];
         selftest_run             <= reg_wdata[PMR_PHY_RUN_BIT];
         bypass_q                 <= reg_wdata[PMR_PHY_BYPASS_BIT];
         led_mode_q               <= reg_wdata[PMR_PHY_LEDCFG_BIT];
         management_port_address  <= reg_wdata[PMR_PHY_ADDR_LSB +: 5];
      end
   end

   // forced or automatic swap
   // crossover is ignored by software when negotiation is off
   // software keeps this off
   always_ff @(posedge core_clk) begin
      if (srst) begin
         media_pair_swap <= 1'b0;
      end else begin
         media_pair_swap <= force_q ||
                            (auto_crossover_enable && auto_cross_decision);
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         fe_q <= 1'b0;
      end else begin
         fe_q <= wr_phy && reg_wdata[PMR_PHY_FE_BIT];
      end
   end
   assign selftest_error_inject = fe_q;

   always_ff @(posedge core_clk) begin
      if (srst) begin
         run_prev_q <= 1'b0;
         pass_q     <= 1'b0;
      end else begin
         run_prev_q <= selftest_run;
         if (!selftest_run) begin
            pass_q <= 1'b0;
         end else if (!run_prev_q) begin
            pass_q <= 1'b1;
         end else if (selftest_error) begin
            pass_q <= 1'b0;
         end
      end
   end

   // =====================================================
   // pause resolution, symmetric and asymmetric cases
   assign lp = local_ability_advert[PMR_ADV_PAUSE_BIT];
   assign la = local_ability_advert[PMR_ADV_ASYM_BIT];
   assign pp = partner_ability_advert[PMR_ADV_PAUSE_BIT];
   assign pa = partner_ability_advert[PMR_ADV_ASYM_BIT];
   assign pause_rx_d = full_duplex_resolved &&
                       ((lp && pp) || (lp && la && !pp && pa));
   assign pause_tx_d = full_duplex_resolved &&
                       ((lp && pp) || (!lp && la && pp && pa));

   always_ff @(posedge core_clk) begin
      if (srst) begin
         prx_q <= 1'b0;
         ptx_q <= 1'b0;
      end else begin
         prx_q <= pause_rx_d;
         ptx_q <= pause_tx_d;
      end
   end
   assign pause_rx_enable = prx_q;
   assign pause_tx_enable = ptx_q;

   // =====================================================
   // read mux, registered
   always_comb begin
      rdata_d = PMR_RDATA_RESET;
      case (reg_addr)
         PMR_ADDR_IFMODE: begin
            rdata_d[PMR_IFM_RMII_BIT]   = rmii_mode_select;
            rdata_d[PMR_IFM_LEGACY_BIT] = legacy_revision_select;
            rdata_d[PMR_IFM_OVF_BIT]    = ovf_q;
            rdata_d[PMR_IFM_UNF_BIT]    = unf_q;
            rdata_d[PMR_IFM_ELAST_LSB +: 2] = elastic_buffer_setting;
         end
         PMR_ADDR_LEDOVR: begin
            rdata_d[PMR_LED_SPD_OVR_BIT] = spd_ovr_q;
            rdata_d[PMR_LED_LNK_OVR_BIT] = lnk_ovr_q;
            rdata_d[PMR_LED_SPD_VAL_BIT] = spd_val_q;
            rdata_d[PMR_LED_LNK_VAL_BIT] = lnk_val_q;
         end
         PMR_ADDR_PHYCTL: begin
            rdata_d[PMR_PHY_AUTO_CROSSOVER_ENABLE_BIT] = auto_crossover_enable;
            rdata_d[PMR_PHY_FORCE_BIT]   = force_q;
            rdata_d[PMR_PHY_PRX_BIT]     = prx_q;
            rdata_d[PMR_PHY_PTX_BIT]     = ptx_q;
            rdata_d[PMR_PHY_FE_BIT]      = fe_q;
            rdata_d[PMR_PHY_PSR_BIT]     = selftest_sequence_select;
            rdata_d[PMR_PHY_PASS_BIT]    = pass_q;
            rdata_d[PMR_PHY_RUN_BIT]     = selftest_run;
            rdata_d[PMR_PHY_BYPASS_BIT]  = bypass_q;
            rdata_d[PMR_PHY_LEDCFG_BIT]  = led_mode_q;
            rdata_d[PMR_PHY_ADDR_LSB +: 5] = management_port_address;
         end
         default: rdata_d = PMR_RDATA_RESET;
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         reg_rdata    <= PMR_RDATA_RESET;
         reg_rd_valid <= 1'b0;
      end else begin
         reg_rd_valid <= reg_rd_en;
         if (reg_rd_en) begin
            reg_rdata <= rdata_d;
         end
      end
   end

   // =====================================================
   // indicator drive
   pmr_indicator #(
      .STRETCH_CYCLES (STRETCH_CYCLES)
   ) u_indicator (
      .core_clk                    (core_clk),
      .srst                        (srst),
      .link_up                     (link_up),
      .speed_100                   (speed_100),
      .activity                    (activity),
      .stretch_bypass              (bypass_q),
      .indicator_mode_select       (led_mode_q),
      .speed_indicator_override    (spd_ovr_q),
      .speed_indicator_force_value (spd_val_q),
      .link_indicator_override     (lnk_ovr_q),
      .link_indicator_force_value  (lnk_val_q),
      .speed_indicator_output      (speed_indicator_output),
      .link_indicator_output       (link_indicator_output)
   );

   // =====================================================
   // checks
   a_ifm_reserved: assert property (
      @(posedge core_clk) disable iff (srst)
      reg_rd_en && reg_addr == PMR_ADDR_IFMODE |=>
         reg_rd_valid && reg_rdata[15:6] == 10'h000)
      else $error("interface mode reserved bits not zero");

   a_rmii_write: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_ifm && !strap_pend_q |=>
         rmii_mode_select == $past(reg_wdata[PMR_IFM_RMII_BIT]))
      else $error("reduced interface select not written");

   a_legacy_hold: assert property (
      @(posedge core_clk) disable iff (srst)
      rmii_mode_select && legacy_revision_select
         && (carrier_sense || rx_data_valid) |=> crs_dv)
      else $error("legacy carrier valid dropped early");

   a_ovf_set_wins: assert property (
      @(posedge core_clk) disable iff (srst)
      rx_fifo_overflow_evt |=> ovf_q ##1 (ovf_q || $past(rd_ifm)))
      else $error("overflow flag lost");

   a_led_reserved: assert property (
      @(posedge core_clk) disable iff (srst)
      reg_rd_en && reg_addr == PMR_ADDR_LEDOVR |=>
         reg_rdata[15:6] == 10'h000 && reg_rdata[3] == 1'b0)
      else $error("override reserved bits not zero");

   a_pair_force: assert property (
      @(posedge core_clk) disable iff (srst)
      force_q |=> media_pair_swap)
      else $error("forced crossover not applied");

   a_pause_half: assert property (
      @(posedge core_clk) disable iff (srst)
      !full_duplex_resolved |=> !pause_rx_enable && !pause_tx_enable)
      else $error("pause resolved in half duplex");

   a_force_pulse: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_phy && reg_wdata[PMR_PHY_FE_BIT] |=>
         selftest_error_inject ##1 (!selftest_error_inject
            || $past(wr_phy && reg_wdata[PMR_PHY_FE_BIT])))
      else $error("force error not one pulse");

   a_pass_cleared: assert property (
      @(posedge core_clk) disable iff (srst)
      !selftest_run |=> !pass_q)
      else $error("pass flag survives stop");

   a_addr_write: assert property (
      @(posedge core_clk) disable iff (srst)
      wr_phy && !strap_pend_q |=>
         management_port_address == $past(reg_wdata[4:0]))
      else $error("port address not written");

endmodule // pmr_regs

// ---- include/pmr_pkg.sv ----
// package: register map, field positions and reset values of the pmr block
// What this block does
// - interface-mode bits 15:6 read zero, ignore writes
// - bit 5 selects MII or reduced MII
// - bit 4 chooses carrier-valid end behaviour
// - bit 3 reads one after FIFO overflow
// - bit 2 reads one after FIFO underflow
// - override register bits 15:6 read zero
// - speed override drives speed force value
// - link override drives link force value
// - override reads return stored bits only
// - bit 15 enables automatic crossover, strap loaded
// - force crossover swaps the media pairs
// - pause receive resolved, full duplex only
// - pause transmit resolved, full duplex only
// - force-error injects one error, self clears
// - self-test run, sequence select, pass latch
// - stretch bypass shows raw indicator events
// - mode one: link steady, speed shows 100
// - mode two: link blinks on activity
// - bits 4:0 hold strap-loaded management address
package pmr_pkg;

   // =====================================================
   // register offsets
   localparam logic [4:0] PMR_ADDR_IFMODE = 5'h17;
   localparam logic [4:0] PMR_ADDR_LEDOVR = 5'h18;
   localparam logic [4:0] PMR_ADDR_PHYCTL = 5'h19;

   // =====================================================
   // interface mode fields
   localparam int PMR_IFM_RMII_BIT   = 5;
   localparam int PMR_IFM_LEGACY_BIT = 4;
   localparam int PMR_IFM_OVF_BIT    = 3;
   localparam int PMR_IFM_UNF_BIT    = 2;
   localparam int PMR_IFM_ELAST_LSB  = 0;
   localparam logic [1:0] PMR_ELAST_RESET = 2'h1;

   // =====================================================
   // indicator override fields
   localparam int PMR_LED_SPD_OVR_BIT = 5;
   localparam int PMR_LED_LNK_OVR_BIT = 4;
   localparam int PMR_LED_SPD_VAL_BIT = 2;
   localparam int PMR_LED_LNK_VAL_BIT = 1;

   // =====================================================
   // phy control fields
   localparam int PMR_PHY_AUTO_CROSSOVER_ENABLE_BIT  = 15;
   localparam int PMR_PHY_FORCE_BIT    = 14;
   localparam int PMR_PHY_PRX_BIT      = 13;
   localparam int PMR_PHY_PTX_BIT      = 12;
   localparam int PMR_PHY_FE_BIT       = 11;
   localparam int PMR_PHY_PSR_BIT      = 10;
   localparam int PMR_PHY_PASS_BIT     = 9;
   localparam int PMR_PHY_RUN_BIT      = 8;
   localparam int PMR_PHY_BYPASS_BIT   = 7;
   localparam int PMR_PHY_LEDCFG_BIT   = 5;
   localparam int PMR_PHY_ADDR_LSB     = 0;

   localparam logic [15:0] PMR_RDATA_RESET = 16'h0000;

   // pause advert bit order within the two-bit slice
   localparam int PMR_ADV_PAUSE_BIT = 0;
   localparam int PMR_ADV_ASYM_BIT  = 1;

   // activity stretch length in core clock cycles
   localparam int PMR_STRETCH_CYCLES = 1024;

   typedef enum logic [1:0] {
      PMR_CRS_IDLE    = 2'b00,
      PMR_CRS_CARRIER = 2'b01,
      PMR_CRS_TAIL    = 2'b10
   } pmr_crs_state_t;

endpackage

// ---- logic/pmr_indicator.sv ----
// link and speed indicator drive with stretch, modes and override
`timescale 1ns/100ps
module pmr_indicator
   import pmr_pkg::*;
#(
   parameter int STRETCH_CYCLES = PMR_STRETCH_CYCLES
) (
   input  wire logic core_clk,
   input  wire logic srst,
   input  wire logic link_up,
   input  wire logic speed_100,
   input  wire logic activity,
   input  wire logic stretch_bypass,
   input  wire logic indicator_mode_select,
   input  wire logic speed_indicator_override,
   input  wire logic speed_indicator_force_value,
   input  wire logic link_indicator_override,
   input  wire logic link_indicator_force_value,
   output logic      speed_indicator_output,
   output logic      link_indicator_output
);

   localparam int CW = $clog2(STRETCH_CYCLES + 1);

   generate
      if (STRETCH_CYCLES < 1) begin : g_bad_stretch
         $error("pmr_indicator: STRETCH_CYCLES must be at least 1");
      end
   endgenerate

   logic [CW-1:0] stretch_q;
   logic          act_seen;
   logic          link_norm;

   // =====================================================
   // activity stretch
   always_ff @(posedge core_clk) begin
      if (srst) begin
         stretch_q <= '0;
      end else if (activity) begin
         stretch_q <= CW'(STRETCH_CYCLES);
      end else if (stretch_q != '0) begin
         stretch_q <= stretch_q - CW'(1);
      end
   end

   assign act_seen = stretch_bypass ? activity
                                    : (activity || stretch_q != '0);

   assign link_norm = indicator_mode_select ? link_up
                                            : (link_up && !act_seen);

   // =====================================================
   // output drive
   always_ff @(posedge core_clk) begin
      if (srst) begin
         speed_indicator_output <= 1'b0;
         link_indicator_output  <= 1'b0;
      end else begin
         speed_indicator_output <= speed_indicator_override
                                   ? speed_indicator_force_value
                                   : speed_100;
         link_indicator_output  <= link_indicator_override
                                   ? link_indicator_force_value
                                   : link_norm;
      end
   end

   a_speed_override: assert property (
      @(posedge core_clk) disable iff (srst)
      speed_indicator_override |=>
         speed_indicator_output == $past(speed_indicator_force_value))
      else $error("speed indicator ignores override");

   a_link_override: assert property (
      @(posedge core_clk) disable iff (srst)
      link_indicator_override |=>
         link_indicator_output == $past(link_indicator_force_value))
      else $error("link indicator ignores override");

   a_bypass_blink: assert property (
      @(posedge core_clk) disable iff (srst)
      stretch_bypass && !indicator_mode_select
         && !link_indicator_override |=>
         link_indicator_output == ($past(link_up) && !$past(activity)))
      else $error("bypassed link indicator not raw");

   a_mode_one_link: assert property (
      @(posedge core_clk) disable iff (srst)
      indicator_mode_select && !link_indicator_override |=>
         link_indicator_output == $past(link_up))
      else $error("mode one link indicator wrong");

endmodule // pmr_indicator

// ---- dv/pmr_mgmt_model.sv ----
// management-side model driving the register port
`timescale 1ns/100ps
module pmr_mgmt_model (
   input  wire logic        core_clk,
   output logic [4:0]       reg_addr,
   output logic             reg_wr_en,
   output logic             reg_rd_en,
   output logic [15:0]      reg_wdata,
   input  wire logic [15:0] reg_rdata,
   input  wire logic        reg_rd_valid
);
   initial begin
      reg_addr = 5'h00;
      reg_wr_en = 1'b0;
      reg_rd_en = 1'b0;
      reg_wdata = 16'h5a5a;
   end
   // caller keeps crossover off without negotiation
   task automatic wr(input logic [4:0] a, input logic [15:0] d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr_en = 1'b1;
      @(negedge core_clk);
      reg_wr_en = 1'b0;
      // stale data would hide a late sample
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] d,
                     output logic v);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd_en = 1'b1;
      @(negedge core_clk);
      reg_rd_en = 1'b0;
      v = reg_rd_valid;
      d = reg_rdata;
   endtask
endmodule // pmr_mgmt_model

// ---- dv/tb_top.sv ----
// self-checking bench for the pmr register block
`timescale 1ns/100ps
module tb_top;
   import pmr_pkg::*;
   logic core_clk = 1'b0, srst = 1'b1;
   logic strap_rmii = 1'b1, strap_auto_crossover_enable = 1'b1, strap_led_mode = 1'b1;
   logic [4:0] strap_port_address = 5'h0a;
   logic rx_fifo_overflow_evt = 0, rx_fifo_underflow_evt = 0;
   logic carrier_sense = 0, rx_data_valid = 0, full_duplex_resolved = 0;
   logic [1:0] local_ability_advert = 0, partner_ability_advert = 0;
   logic auto_cross_decision = 0, selftest_error = 0, activity = 0;
   logic link_up = 0, speed_100 = 0, vv;
   logic [15:0] rv;
   wire [4:0] reg_addr, management_port_address;
   wire [15:0] reg_wdata, reg_rdata;
   wire [1:0] elastic_buffer_setting;
   wire reg_wr_en, reg_rd_en, reg_rd_valid, rmii_mode_select, crs_dv;
   wire legacy_revision_select, auto_crossover_enable, media_pair_swap;
   wire pause_rx_enable, pause_tx_enable, selftest_run;
   wire selftest_sequence_select, selftest_error_inject;
   wire speed_indicator_output, link_indicator_output;
   int n_mismatch = 0, n_compared = 0, k;
   pmr_regs #(.STRETCH_CYCLES(4)) u_pmr_regs (.*);
   pmr_mgmt_model u_pmr_mgmt_model (.*);
   always #20 core_clk = ~core_clk;
   // =====================================================
   // checks
   task automatic chk(input string s, input logic [15:0] e, g);
      n_compared++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rchk(input logic [4:0] a, input logic [15:0] e);
      u_pmr_mgmt_model.rd(a, rv, vv);
      chk("rd_valid", 16'h0001, {15'h0, vv});
      chk("rdata", e, rv);
   endtask
   task automatic bchk(input string s, input logic e, g);
      chk(s, {15'h0, e}, {15'h0, g});
   endtask
   task automatic cchk(input logic e);
      @(negedge core_clk);
      bchk("crs_dv", e, crs_dv);
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // =====================================================
   // scenarios
   task automatic t_ifmode;
      rchk(PMR_ADDR_IFMODE, 16'h0021);
      rchk(PMR_ADDR_LEDOVR, 16'h0000);
      u_pmr_mgmt_model.wr(PMR_ADDR_IFMODE, 16'hffff);
      rchk(PMR_ADDR_IFMODE, 16'h0033);
      chk("legacy", 16'h0001, {15'h0, legacy_revision_select});
      chk("elastic", 16'h0003, {14'h0, elastic_buffer_setting});
      u_pmr_mgmt_model.wr(PMR_ADDR_IFMODE, 16'h0002);
      chk("rmii", 16'h0000, {15'h0, rmii_mode_select});
      rchk(5'h10, 16'h0000);
   endtask
   task automatic t_events;
      @(negedge core_clk) rx_fifo_overflow_evt = 1;
      @(negedge core_clk) rx_fifo_overflow_evt = 0;
      rx_fifo_underflow_evt = 1;
      @(negedge core_clk) rx_fifo_underflow_evt = 0;
      rchk(PMR_ADDR_IFMODE, 16'h000e);
      rchk(PMR_ADDR_IFMODE, 16'h0002);
   endtask
   task automatic t_crs;
      // reduced mode: tail toggles while data drains
      u_pmr_mgmt_model.wr(PMR_ADDR_IFMODE, 16'h0020);
      carrier_sense = 1;
      rx_data_valid = 1;
      cchk(1'b1);
      carrier_sense = 0;
      cchk(1'b0);
      cchk(1'b1);
      cchk(1'b0);
      rx_data_valid = 0;
      cchk(1'b0);
      // legacy revision holds high until data ends
      u_pmr_mgmt_model.wr(PMR_ADDR_IFMODE, 16'h0030);
      carrier_sense = 1;
      rx_data_valid = 1;
      cchk(1'b1);
      carrier_sense = 0;
      cchk(1'b1);
      cchk(1'b1);
      rx_data_valid = 0;
      cchk(1'b0);
   endtask
   task automatic t_led;
      u_pmr_mgmt_model.wr(PMR_ADDR_LEDOVR, 16'hffff);
      rchk(PMR_ADDR_LEDOVR, 16'h0036);
      chk("spd_led", 16'h0001, {15'h0, speed_indicator_output});
      chk("lnk_led", 16'h0001, {15'h0, link_indicator_output});
      u_pmr_mgmt_model.wr(PMR_ADDR_LEDOVR, 16'h0000);
      @(negedge core_clk);
      bchk("spd_led", 1'b0, speed_indicator_output);
      bchk("lnk_led", 1'b0, link_indicator_output);
      link_up = 1;
      speed_100 = 1;
      repeat (3) @(negedge core_clk);
      chk("spd_led", 16'h0001, {15'h0, speed_indicator_output});
      chk("lnk_led", 16'h0001, {15'h0, link_indicator_output});
      rchk(PMR_ADDR_LEDOVR, 16'h0000);
   endtask
   task automatic t_phy;
      auto_cross_decision = 1;
      rchk(PMR_ADDR_PHYCTL, 16'h802a);
      chk("addr", 16'h000a, {11'h0, management_port_address});
      bchk("mdix", 1'b1, auto_crossover_enable);
      bchk("swap", 1'b1, media_pair_swap);
      local_ability_advert = 2'b01;
      partner_ability_advert = 2'b01;
      full_duplex_resolved = 1;
      // no negotiation here, so automatic crossover is turned off and the swap is forced
      u_pmr_mgmt_model.wr(PMR_ADDR_PHYCTL, 16'h4c2a);
      k = selftest_error_inject;
      repeat (3) @(negedge core_clk) k += selftest_error_inject;
      chk("inject", 16'h0001, k[15:0]);
      chk("swap", 16'h0001, {15'h0, media_pair_swap});
      chk("prx", 16'h0001, {15'h0, pause_rx_enable});
      chk("ptx", 16'h0001, {15'h0, pause_tx_enable});
      bchk("mdix", 1'b0, auto_crossover_enable);
      full_duplex_resolved = 0;
      rchk(PMR_ADDR_PHYCTL, 16'h442a);
      u_pmr_mgmt_model.wr(PMR_ADDR_PHYCTL, 16'h052a);
      rchk(PMR_ADDR_PHYCTL, 16'h072a);
      chk("run", 16'h0001, {15'h0, selftest_run});
      bchk("psr", 1'b1, selftest_sequence_select);
      bchk("swap", 1'b0, media_pair_swap);
      @(negedge core_clk) selftest_error = 1;
      @(negedge core_clk) selftest_error = 0;
      rchk(PMR_ADDR_PHYCTL, 16'h052a);
      local_ability_advert = 2'b10;
      partner_ability_advert = 2'b11;
      full_duplex_resolved = 1;
      repeat (2) @(negedge core_clk);
      bchk("prx", 1'b0, pause_rx_enable);
      bchk("ptx", 1'b1, pause_tx_enable);
      // stretch of four cycles, as set at the instance
      u_pmr_mgmt_model.wr(PMR_ADDR_PHYCTL, 16'h050a);
      @(negedge core_clk) activity = 1;
      @(negedge core_clk) activity = 0;
      bchk("lnk_led", 1'b0, link_indicator_output);
      repeat (4) @(negedge core_clk);
      bchk("lnk_led", 1'b0, link_indicator_output);
      @(negedge core_clk);
      bchk("lnk_led", 1'b1, link_indicator_output);
      u_pmr_mgmt_model.wr(PMR_ADDR_PHYCTL, 16'h058a);
      @(negedge core_clk) activity = 1;
      @(negedge core_clk) activity = 0;
      bchk("lnk_led", 1'b0, link_indicator_output);
      @(negedge core_clk);
      bchk("lnk_led", 1'b1, link_indicator_output);
   endtask
   // =====================================================
   // main sequence and watchdog
   initial begin
      repeat (3) @(negedge core_clk);
      srst = 0;
      t_ifmode();
      t_events();
      t_crs();
      t_led();
      t_phy();
      end_of_test();
   end
   initial begin
      #40000;
      n_mismatch++;
      end_of_test();
   end
endmodule // tb_top
